// file: core/spcr_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "spcr_defines.svh"

module spcr_top #(
    // Arbitrary value
    parameter logic [7:0] REVISION = 8'h0a,
    // Arbitrary value
    parameter logic [7:0] DEVICE_IDENTIFIER = 8'h5c
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Serial port pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe_n,
    output logic sdo,
    output logic sdo_oe_n,
    // Multifunction pin selects M[7:3]
    input wire logic [4:0] mf_select,
    // Device events
    output logic soft_reset_pulse,
    output logic download_req,
    output logic transfer_pulse,
    // System clock PLL controls
    output logic ext_loop_filter,
    output logic pump_manual,
    output logic [2:0] pump_current_code,
    output logic [10:0] pump_current_ua,
    output logic lock_timer_enable,
    output logic [10:0] lock_timer_depth
);

    // ****************************************************************
    // Pin synchronisers and edge detection
    // ****************************************************************
    logic s_sclk;
    logic s_cs_n;
    logic s_sdio;
    logic sclk_d;
    logic sclk_rise;
    logic sclk_fall;

    spcr_sync #(.W(3), .RESET_VAL(3'h2)) u_sync (
        .clk(clk),
        .reset(reset),
        .async_in({sclk, cs_n, sdio_in}),
        .sync_out({s_sclk, s_cs_n, s_sdio})
    );

    assign sclk_rise = s_sclk & ~sclk_d;
    assign sclk_fall = ~s_sclk & sclk_d;

    logic [7:0] port_cfg;
    logic readback_sel;
    logic [7:0] pll_buffer;
    logic [7:0] pll_active;
    logic lsb_first;
    logic four_wire;
    assign lsb_first = port_cfg[`SPCR_CFG_LSB_FIRST];
    assign four_wire = port_cfg[`SPCR_CFG_FOUR_WIRE];

    // ****************************************************************
    // Serial port state machine
    // ****************************************************************
    spcr_pkg::spcr_state_t state;
    spcr_pkg::spcr_state_t next_state;
    logic [4:0] bit_cnt;
    logic [4:0] next_bit_cnt;
    logic is_read;
    logic next_is_read;
    logic [12:0] addr;
    logic [12:0] next_addr;
    logic wr_en;
    logic out_load;
    logic out_shift;
    logic [15:0] in_data;
    logic [15:0] in_next;
    logic [7:0] wr_byte;
    logic [7:0] rd_data;
    logic [7:0] out_data;
    logic out_bit;

    spcr_shifter #(.W(16)) u_in (
        .clk(clk),
        .reset(reset),
        .load(1'b0),
        .load_value(16'h0000),
        .shift_en(sclk_rise & ~s_cs_n),
        .lsb_first(lsb_first),
        .serial_in(s_sdio),
        .data(in_data),
        .data_next(in_next),
        .serial_out()
    );
    spcr_shifter #(.W(8)) u_out (
        .clk(clk),
        .reset(reset),
        .load(out_load),
        .load_value(rd_data),
        .shift_en(out_shift),
        .lsb_first(lsb_first),
        .serial_in(1'b0),
        .data(out_data),
        .data_next(),
        .serial_out(out_bit)
    );

    // Byte lands in the low half MSB first, in the high half LSB first
    assign wr_byte = lsb_first ? in_next[15:8] : in_next[7:0];

    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_is_read = is_read;
        next_addr = addr;
        wr_en = 1'b0;
        out_load = 1'b0;
        out_shift = 1'b0;
        if (s_cs_n) begin
            next_state = spcr_pkg::spcr_idle;
            next_bit_cnt = 5'd0;
        end else begin
            case (state)
                spcr_pkg::spcr_idle: begin
                    next_state = spcr_pkg::spcr_instr;
                    next_bit_cnt = 5'd0;
                end
                spcr_pkg::spcr_instr: begin
                    if (sclk_rise) begin
                        if (bit_cnt == `SPCR_INSTR_LAST) begin
                            next_state = spcr_pkg::spcr_data;
                            next_bit_cnt = 5'd0;
                            next_is_read = in_next[`SPCR_INSTR_READ];
                            next_addr = in_next[`SPCR_INSTR_ADDR_HI:0];
                        end else begin
                            next_bit_cnt = bit_cnt + 5'd1;
                        end
                    end
                end
                spcr_pkg::spcr_data: begin
                    if (sclk_rise) begin
                        if (bit_cnt == `SPCR_BYTE_LAST) begin
                            next_bit_cnt = 5'd0;
                            wr_en = ~is_read;
                            // Streaming walks up LSB first, down MSB first
                            next_addr = lsb_first ? addr + 13'h0001 : addr - 13'h0001;
                        end else begin
                            next_bit_cnt = bit_cnt + 5'd1;
                        end
                    end
                    if (sclk_fall && is_read) begin
                        out_load = (bit_cnt == 5'd0);
                        out_shift = (bit_cnt != 5'd0);
                    end
                end
                default: next_state = spcr_pkg::spcr_idle;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sclk_d <= 1'b0;
            state <= spcr_pkg::spcr_idle;
            bit_cnt <= 5'd0;
            is_read <= 1'b0;
            addr <= 13'h0000;
        end else begin
            sclk_d <= s_sclk;
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            is_read <= next_is_read;
            addr <= next_addr;
        end
    end

    logic driving;
    // Shared pin turns round only while a read byte is shifted out
    assign driving = ~s_cs_n & is_read & (state == spcr_pkg::spcr_data);
    assign sdio_out = out_bit;
    assign sdo = out_bit;
    assign sdio_oe_n = ~(driving & ~four_wire);
    assign sdo_oe_n = ~(driving & four_wire);

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [7:0] next_port_cfg;
    logic next_readback_sel;
    logic [7:0] next_pll_buffer;
    logic [7:0] next_pll_active;
    logic next_soft_reset;
    logic next_download;
    logic next_transfer;
    logic [10:0] next_ua;
    logic [10:0] next_depth;
    always_comb begin
        next_port_cfg = port_cfg;
        next_readback_sel = readback_sel;
        next_pll_buffer = pll_buffer;
        next_pll_active = pll_active;
        next_soft_reset = 1'b0;
        next_download = 1'b0;
        next_transfer = 1'b0;
        if (wr_en) begin
            case (addr)
                `SPCR_ADDR_PORT_CFG: begin
                    next_port_cfg = wr_byte & `SPCR_CFG_WRITE_MASK;
                    if (wr_byte[`SPCR_CFG_SOFT_RESET]) begin
                        next_soft_reset = 1'b1;
                        next_download = |mf_select;
                    end
                end
                `SPCR_ADDR_READBACK: next_readback_sel = wr_byte[0];
                `SPCR_ADDR_TRANSFER: next_transfer = wr_byte[0];
                `SPCR_ADDR_PLL_CTRL: next_pll_buffer = wr_byte;
                default: ; // Revision, identity and unused addresses ignore writes
            endcase
        end
        if (transfer_pulse) begin
            next_pll_active = pll_buffer;
        end
        // Soft reset returns every register to default, bit 5 included
        if (soft_reset_pulse) begin
            next_port_cfg = `SPCR_CFG_DEFAULT;
            next_readback_sel = 1'b0;
            next_pll_buffer = `SPCR_PLL_DEFAULT;
            next_pll_active = `SPCR_PLL_DEFAULT;
        end
        // Automatic mode reports zero since the current is not ours to set
        if (next_pll_active[`SPCR_PLL_PUMP_MANUAL]) begin
            next_ua = 11'(({8'h00, next_pll_active[`SPCR_PLL_PUMP_HI:`SPCR_PLL_PUMP_LO]} + 11'd1)
                      * `SPCR_PUMP_STEP_UA);
        end else begin
            next_ua = 11'd0;
        end
        next_depth = `SPCR_LOCK_BASE << next_pll_active[`SPCR_PLL_DEPTH_HI:`SPCR_PLL_DEPTH_LO];
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            port_cfg <= `SPCR_CFG_DEFAULT;
            readback_sel <= 1'b0;
            pll_buffer <= `SPCR_PLL_DEFAULT;
            pll_active <= `SPCR_PLL_DEFAULT;
            soft_reset_pulse <= 1'b0;
            download_req <= 1'b0;
            transfer_pulse <= 1'b0;
            pump_current_ua <= 11'd0;
            lock_timer_depth <= `SPCR_LOCK_BASE;
        end else begin
            port_cfg <= next_port_cfg;
            readback_sel <= next_readback_sel;
            pll_buffer <= next_pll_buffer;
            pll_active <= next_pll_active;
            soft_reset_pulse <= next_soft_reset;
            download_req <= next_download;
            transfer_pulse <= next_transfer;
            pump_current_ua <= next_ua;
            lock_timer_depth <= next_depth;
        end
    end

    assign ext_loop_filter = pll_active[`SPCR_PLL_EXT_FILTER];
    assign pump_manual = pll_active[`SPCR_PLL_PUMP_MANUAL];
    assign pump_current_code = pll_active[`SPCR_PLL_PUMP_HI:`SPCR_PLL_PUMP_LO];
    assign lock_timer_enable = ~pll_active[`SPCR_PLL_LOCK_DISABLE];

    always_comb begin
        case (addr)
            `SPCR_ADDR_PORT_CFG: rd_data = port_cfg | `SPCR_CFG_READ_ONES;
            `SPCR_ADDR_REVISION: rd_data = REVISION;
            `SPCR_ADDR_DEVICE_IDENTIFIER: rd_data = DEVICE_IDENTIFIER;
            `SPCR_ADDR_READBACK: rd_data = {7'h00, readback_sel};
            `SPCR_ADDR_PLL_CTRL: rd_data = readback_sel ? pll_buffer : pll_active;
            default: rd_data = 8'h00;
        endcase
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    long_instr_one_a: assert property ((addr == `SPCR_ADDR_PORT_CFG) |-> rd_data[4])
        else $error("long instruction bit reads zero");
    revision_fixed_a: assert property ((addr == `SPCR_ADDR_REVISION) |-> rd_data == REVISION)
        else $error("revision readback wrong");
    device_identifier_fixed_a: assert property ((addr == `SPCR_ADDR_DEVICE_IDENTIFIER) |-> rd_data == DEVICE_IDENTIFIER)
        else $error("identification readback wrong");
    readback_source_a: assert property ((addr == `SPCR_ADDR_PLL_CTRL)
        |-> rd_data == (readback_sel ? pll_buffer : pll_active))
        else $error("readback source wrong");
    transfer_copy_a: assert property ((wr_en && addr == `SPCR_ADDR_TRANSFER && wr_byte[0] && !soft_reset_pulse)
        |=> transfer_pulse ##1 (pll_active == $past(pll_buffer) || $past(soft_reset_pulse)))
        else $error("transfer did not copy buffer");
    transfer_self_clear_a: assert property (transfer_pulse |=> !transfer_pulse)
        else $error("transfer strobe did not clear");
    active_hold_a: assert property ((!transfer_pulse && !soft_reset_pulse) |=> $stable(pll_active))
        else $error("active copy changed without transfer");
    three_wire_pin_a: assert property (!four_wire |-> sdo_oe_n)
        else $error("separate output driven in three-wire mode");
    soft_reset_clear_a: assert property (soft_reset_pulse
        |=> (port_cfg == `SPCR_CFG_DEFAULT && pll_active == `SPCR_PLL_DEFAULT))
        else $error("soft reset did not restore defaults");
    download_gate_a: assert property (download_req |-> soft_reset_pulse && $past(mf_select) != 5'h00)
        else $error("download without soft reset or selects");
    pump_current_a: assert property (pump_manual |-> pump_current_ua
        == 11'(({8'h00, pump_current_code} + 11'd1) * `SPCR_PUMP_STEP_UA))
        else $error("pump current scale wrong");
    lock_depth_a: assert property (lock_timer_depth == (`SPCR_LOCK_BASE << pll_active[1:0]))
        else $error("lock depth wrong");
    read_byte_c: cover property (out_load ##[1:200] out_shift);
    transfer_c: cover property (wr_en && addr == `SPCR_ADDR_PLL_CTRL ##[1:400] transfer_pulse);
    soft_reset_c: cover property (soft_reset_pulse && download_req);
    four_wire_read_c: cover property (!sdo_oe_n);

endmodule : spcr_top
`default_nettype wire

// file: core/spcr_defines.svh
`ifndef SPCR_DEFINES_SVH
`define SPCR_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define SPCR_ADDR_PORT_CFG 13'h0000
`define SPCR_ADDR_RESERVED 13'h0001
`define SPCR_ADDR_REVISION 13'h0002
`define SPCR_ADDR_DEVICE_IDENTIFIER 13'h0003
`define SPCR_ADDR_READBACK 13'h0004
`define SPCR_ADDR_TRANSFER 13'h0005
`define SPCR_ADDR_PLL_CTRL 13'h0100

// ****************************************************************
// Field positions
// ****************************************************************
`define SPCR_CFG_FOUR_WIRE 7
`define SPCR_CFG_LSB_FIRST 6
`define SPCR_CFG_SOFT_RESET 5
`define SPCR_CFG_LONG_INSTR 4
`define SPCR_PLL_EXT_FILTER 7
`define SPCR_PLL_PUMP_MANUAL 6
`define SPCR_PLL_PUMP_HI 5
`define SPCR_PLL_PUMP_LO 3
`define SPCR_PLL_LOCK_DISABLE 2
`define SPCR_PLL_DEPTH_HI 1
`define SPCR_PLL_DEPTH_LO 0
`define SPCR_INSTR_READ 15
`define SPCR_INSTR_ADDR_HI 12

// ****************************************************************
// Reset values and masks
// ****************************************************************
`define SPCR_CFG_WRITE_MASK 8'he0
`define SPCR_CFG_READ_ONES 8'h10
`define SPCR_CFG_DEFAULT 8'h00
`define SPCR_PLL_DEFAULT 8'h18

// ****************************************************************
// Counts and scales
// ****************************************************************
`define SPCR_INSTR_LAST 5'd15
`define SPCR_BYTE_LAST 5'd7
`define SPCR_PUMP_STEP_UA 11'd125
`define SPCR_LOCK_BASE 11'd128

`endif

// file: core/spcr_pkg.sv
package spcr_pkg;

    typedef enum logic [1:0] {
        spcr_idle = 2'b00,
        spcr_instr = 2'b01,
        spcr_data = 2'b10
    } spcr_state_t;

endpackage : spcr_pkg

// file: core/spcr_sync.sv
`timescale 1ns/1ps
`default_nettype none

module spcr_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] stage1;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (reset) begin
            stage1 <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : spcr_sync

`default_nettype wire

// file: core/spcr_shifter.sv
`timescale 1ns/1ps
`default_nettype none

module spcr_shifter #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Control
    input wire logic load,
    input wire logic [W-1:0] load_value,
    input wire logic shift_en,
    input wire logic lsb_first,
    input wire logic serial_in,
    // Results
    output logic [W-1:0] data,
    output logic [W-1:0] data_next,
    output logic serial_out
);

    logic [W-1:0] next_data;

    always_comb begin
        if (lsb_first) begin
            data_next = {serial_in, data[W-1:1]};
        end else begin
            data_next = {data[W-2:0], serial_in};
        end
        next_data = data;
        if (load) begin
            next_data = load_value;
        end else if (shift_en) begin
            next_data = data_next;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            data <= '0;
        end else begin
            data <= next_data;
        end
    end

    assign serial_out = lsb_first ? data[0] : data[W-1];

endmodule : spcr_shifter

`default_nettype wire

// file: verification/spcr_host.sv
`timescale 1ns/1ps
`default_nettype none

module spcr_host (
    // Clock
    input wire logic clk,
    // Serial pins
    output var logic sclk,
    output var logic cs_n,
    output var logic h_bit,
    output var logic h_oe_n,
    input wire logic sdio_wire,
    input wire logic sdo,
    input wire logic sdo_oe_n
);
    logic lsb;
    logic four;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        h_bit = 1'b0;
        h_oe_n = 1'b1;
        lsb = 1'b0;
        four = 1'b0;
    end

    // ********
    // One bit: four clk low, four clk high, 160 ns
    // ********
    task automatic bit_slot(output logic got);
        repeat (4) @(negedge clk);
        sclk = 1'b1;
        repeat (4) @(negedge clk);
        // Late in the high phase, so the device's sync delay has passed
        got = four ? (sdo_oe_n ? ~sdo : sdo) : sdio_wire;
        sclk = 1'b0;
    endtask : bit_slot

    task automatic xfer(input logic rd, input logic [12:0] addr, input logic [7:0] wd, input int nb,
                        output logic [7:0] rdv);
        logic [15:0] ins;
        logic got;
        ins = {rd, 2'b00, addr};
        rdv = 8'h00;
        cs_n = 1'b0;
        h_oe_n = 1'b0;
        for (int i = 0; i < 16; i++) begin
            h_bit = lsb ? ins[i] : ins[15 - i];
            bit_slot(got);
        end
        h_oe_n = rd;
        for (int i = 0; i < nb; i++) begin
            h_bit = lsb ? wd[i] : wd[7 - i];
            bit_slot(got);
            rdv[lsb ? i : 7 - i] = got;
        end
        repeat (4) @(negedge clk);
        cs_n = 1'b1;
        h_oe_n = 1'b1;
        repeat (8) @(negedge clk);
    endtask : xfer
endmodule : spcr_host

`default_nettype wire

// file: verification/spcr_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module spcr_top_tb;
    typedef struct packed {logic rd; logic [12:0] a; logic [7:0] d; logic [7:0] e;} spcr_row_t;
    localparam logic [7:0] REV = 8'h0a; // Arbitrary value
    localparam logic [7:0] DEV = 8'h5c; // Arbitrary value

    // ********
    // Wiring
    // ********
    logic clk, reset, sclk, cs_n, sdio_in, sdio_out, sdio_oe_n, sdo, sdo_oe_n, h_bit, h_oe_n;
    logic soft_reset_pulse, download_req, transfer_pulse, ext_loop_filter, pump_manual, lock_timer_enable;
    logic [4:0] mf_select;
    logic [2:0] pump_current_code;
    logic [10:0] pump_current_ua, lock_timer_depth;
    int miscompares = 0;
    int n_compared = 0;
    int n_srst = 0;
    int n_dl = 0;
    int n_xfer = 0;

    // Shared pin: nobody driving shows the inverse of the last host bit
    assign sdio_in = !sdio_oe_n ? sdio_out : (!h_oe_n ? h_bit : ~h_bit);

    spcr_top #(.REVISION(REV), .DEVICE_IDENTIFIER(DEV)) uut (.clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n),
        .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
        .mf_select(mf_select), .soft_reset_pulse(soft_reset_pulse), .download_req(download_req),
        .transfer_pulse(transfer_pulse), .ext_loop_filter(ext_loop_filter), .pump_manual(pump_manual),
        .pump_current_code(pump_current_code), .pump_current_ua(pump_current_ua),
        .lock_timer_enable(lock_timer_enable), .lock_timer_depth(lock_timer_depth));

    spcr_host u_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .h_bit(h_bit), .h_oe_n(h_oe_n), .sdio_wire(sdio_in),
        .sdo(sdo), .sdo_oe_n(sdo_oe_n));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Pulses counted away from the edge that launches them
    always @(negedge clk) begin
        n_srst += int'(soft_reset_pulse === 1'b1);
        n_dl += int'(download_req === 1'b1);
        n_xfer += int'(transfer_pulse === 1'b1);
    end

    // ********
    // Checking helpers
    // ********
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic acc(input logic rd, input logic [12:0] a, input logic [7:0] d, input logic [7:0] e);
        logic [7:0] r;
        u_host.xfer(rd, a, d, 8, r);
        if (rd) begin
            chk({3'b000, r}, {3'b000, e});
        end
    endtask : acc

    task automatic outs(input logic [10:0] f, m, c, ua, en, dp);
        chk({10'h000, ext_loop_filter}, f);
        chk({10'h000, pump_manual}, m);
        chk({8'h00, pump_current_code}, c);
        chk(pump_current_ua, ua);
        chk({10'h000, lock_timer_enable}, en);
        chk(lock_timer_depth, dp);
    endtask : outs

    task automatic print_verdict;
        if (miscompares == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    // ********
    // Ordinary accesses
    // ********
    spcr_row_t rows [16] = '{
        '{1'b1, 13'h0000, 8'h00, 8'h10},
        '{1'b0, 13'h0000, 8'h1f, 8'h00},
        '{1'b1, 13'h0000, 8'h00, 8'h10},
        '{1'b0, 13'h0002, 8'hff, 8'h00},
        '{1'b1, 13'h0002, 8'h00, REV},
        '{1'b1, 13'h0003, 8'h00, DEV},
        '{1'b0, 13'h0001, 8'haa, 8'h00},
        '{1'b1, 13'h0001, 8'h00, 8'h00},
        '{1'b1, 13'h0100, 8'h00, 8'h18},
        '{1'b0, 13'h0100, 8'hd6, 8'h00},
        '{1'b1, 13'h0100, 8'h00, 8'h18},
        '{1'b0, 13'h0004, 8'h01, 8'h00},
        '{1'b1, 13'h0004, 8'h00, 8'h01},
        '{1'b1, 13'h0100, 8'h00, 8'hd6},
        '{1'b0, 13'h0004, 8'h00, 8'h00},
        '{1'b1, 13'h0100, 8'h00, 8'h18}};

    initial begin
        logic [2:0] cc;
        logic [7:0] r8;
        reset = 1'b1;
        mf_select = 5'h00;
        repeat (20) @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        chk({10'h000, sdio_oe_n}, 11'h001);
        chk({10'h000, sdo_oe_n}, 11'h001);
        outs(11'h0, 11'h0, 11'h3, 11'h0, 11'h1, 11'd128);
        foreach (rows[i]) acc(rows[i].rd, rows[i].a, rows[i].d, rows[i].e);
        outs(11'h0, 11'h0, 11'h3, 11'h0, 11'h1, 11'd128);
        acc(1'b0, 13'h0005, 8'h01, 8'h00);
        chk(11'(n_xfer), 11'd1);
        outs(11'h1, 11'h1, 11'h2, 11'd375, 11'h0, 11'd512);
        // Every pump code and every depth code
        for (int c = 0; c < 8; c++) begin
            cc = 3'(c);
            acc(1'b0, 13'h0100, {2'b01, cc, 1'b0, cc[1:0]}, 8'h00);
            acc(1'b0, 13'h0005, 8'h01, 8'h00);
            outs(11'h0, 11'h1, {8'h00, cc}, (11'(cc) + 11'd1) * 11'd125, 11'h1, 11'd128 << cc[1:0]);
        end
        acc(1'b0, 13'h0100, 8'h00, 8'h00);
        acc(1'b0, 13'h0005, 8'h01, 8'h00);
        outs(11'h0, 11'h0, 11'h0, 11'h0, 11'h1, 11'd128);
        // ********
        // Awkward cases
        // ********
        u_host.xfer(1'b0, 13'h0004, 8'hff, 4, r8); // Aborted after half a byte
        acc(1'b1, 13'h0004, 8'h00, 8'h00);
        acc(1'b0, 13'h0000, 8'h80, 8'h00);
        u_host.four = 1'b1;
        acc(1'b1, 13'h0003, 8'h00, DEV);
        acc(1'b1, 13'h0000, 8'h00, 8'h90);
        acc(1'b0, 13'h0000, 8'h00, 8'h00);
        u_host.four = 1'b0;
        acc(1'b0, 13'h0000, 8'h40, 8'h00);
        u_host.lsb = 1'b1;
        acc(1'b1, 13'h0003, 8'h00, DEV);
        acc(1'b1, 13'h0000, 8'h00, 8'h50);
        acc(1'b0, 13'h0000, 8'h00, 8'h00);
        u_host.lsb = 1'b0;
        acc(1'b0, 13'h0100, 8'hc4, 8'h00);
        acc(1'b0, 13'h0005, 8'h01, 8'h00);
        outs(11'h1, 11'h1, 11'h0, 11'd125, 11'h0, 11'd128);
        acc(1'b0, 13'h0004, 8'h01, 8'h00);
        acc(1'b0, 13'h0000, 8'h20, 8'h00);
        chk(11'(n_srst), 11'd1);
        chk(11'(n_dl), 11'd0);
        outs(11'h0, 11'h0, 11'h3, 11'h0, 11'h1, 11'd128);
        acc(1'b1, 13'h0004, 8'h00, 8'h00);
        acc(1'b1, 13'h0000, 8'h00, 8'h10);
        mf_select = 5'h08;
        acc(1'b0, 13'h0000, 8'h20, 8'h00);
        chk(11'(n_srst), 11'd2);
        chk(11'(n_dl), 11'd1);
        chk(11'(n_xfer), 11'd11);
        // Hardware reset in mid-run
        acc(1'b0, 13'h0100, 8'hd6, 8'h00);
        acc(1'b0, 13'h0005, 8'h01, 8'h00);
        acc(1'b0, 13'h0004, 8'h01, 8'h00);
        outs(11'h1, 11'h1, 11'h2, 11'd375, 11'h0, 11'd512);
        reset = 1'b1;
        repeat (3) @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        outs(11'h0, 11'h0, 11'h3, 11'h0, 11'h1, 11'd128);
        acc(1'b1, 13'h0004, 8'h00, 8'h00);
        acc(1'b1, 13'h0100, 8'h00, 8'h18);
        acc(1'b1, 13'h0000, 8'h00, 8'h10);
        print_verdict;
    end

    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        print_verdict;
    end
endmodule : spcr_top_tb

`default_nettype wire
